// File: core/leadoff_cfg_pkg.sv
// package for the lead-off and channel one configuration bank
// assumes a byte-wide register map reached over a 32-bit wishbone slave
package leadoff_cfg_pkg;
  // register indices in the byte map, byte address is four times the index
  localparam logic [7:0] lead_off_control_idx = 8'h03;
  localparam logic [7:0] channel_one_settings_idx = 8'h04;
  localparam int addr_width = 8;
  // lead-off field positions
  localparam int thresh_lsb = 5;
  localparam int fixed_one_pos = 4;
  localparam int current_lsb = 2;
  localparam int fixed_zero_pos = 1;
  localparam int detect_ac_pos = 0;
  // channel one field positions
  localparam int powerdown_pos = 7;
  localparam int gain_lsb = 4;
  localparam int mux_lsb = 0;
  // reset values: bit 4 of lead-off reads as its fixed one
  localparam logic [7:0] lead_off_control_rst = 8'h10;
  localparam logic [7:0] channel_one_settings_rst = 8'h00;
  localparam logic [7:0] lead_off_fixed_mask = 8'h12;
  // reset values of the decoded controls: code zero of every field
  localparam logic [7:0] thresh_sel_rst = 8'h01;
  localparam logic [3:0] current_sel_rst = 4'h1;
  localparam logic [6:0] gain_sel_rst = 7'h01;
  localparam logic [9:0] source_sel_rst = 10'h001;
  // input source codes
  typedef enum logic [3:0] {
    src_electrode = 4'h0, src_shorted = 4'h1, src_drive_measure = 4'h2,
    src_supply = 4'h3, src_temperature = 4'h4, src_test = 4'h5,
    src_drive_pos = 4'h6, src_drive_neg = 4'h7, src_drive_both = 4'h8,
    src_third_pair = 4'h9
  } input_source_t;
  // wishbone slave state, gray along idle -> ack
  typedef enum logic [0:0] {
    bus_idle = 1'b0,
    bus_ack = 1'b1
  } bus_state_t;
endpackage

// File: core/cfg_regs_if.sv
// interface carrying stored configuration bytes from the bus slave to the decoder
// assumes a single clock domain
interface cfg_regs_if;
  logic [7:0] lead_off_control;
  logic [7:0] channel_one_settings;
  modport store (output lead_off_control, output channel_one_settings);
  modport decode (input lead_off_control, input channel_one_settings);
endinterface

// File: core/cfg_decode.sv
// combinational decode of configuration bytes into analog control selects
// assumes the bytes are registered upstream; outputs are re-registered by the top
module cfg_decode
  import leadoff_cfg_pkg::*;
(
  // stored configuration
  cfg_regs_if.decode regs,
  // decoded controls
  output logic [7:0] thresh_pos_sel_o,
  output logic [7:0] thresh_neg_sel_o,
  output logic [3:0] current_sel_o,
  output logic [9:0] source_sel_o,
  output logic [6:0] gain_sel_o,
  output logic source_reserved_o
);
  logic [2:0] thresh;
  logic [1:0] cur;
  logic [2:0] gain;
  logic [3:0] mux;

  // field extraction
  assign thresh = regs.lead_off_control[thresh_lsb +: 3];
  assign cur = regs.lead_off_control[current_lsb +: 2];
  assign gain = regs.channel_one_settings[gain_lsb +: 3];
  assign mux = regs.channel_one_settings[mux_lsb +: 4];

  // one-hot selects, none set for gain code 7 or a reserved source; positive and negative levels share one code
  always_comb begin
    thresh_pos_sel_o = 8'h00;
    thresh_neg_sel_o = 8'h00;
    current_sel_o = 4'h0;
    source_sel_o = 10'h000;
    gain_sel_o = 7'h00;
    source_reserved_o = 1'b0;
    thresh_pos_sel_o[thresh] = 1'b1;
    thresh_neg_sel_o[thresh] = 1'b1;
    current_sel_o[cur] = 1'b1;
    if (gain != 3'h7) begin
      gain_sel_o[gain] = 1'b1;
    end
    if (mux <= src_third_pair) begin
      source_sel_o[mux] = 1'b1;
    end else begin
      source_reserved_o = 1'b1;
    end
  end
endmodule

// File: core/leadoff_and_channel_config.sv
// top of the lead-off and channel one configuration bank
// assumes a classic wishbone master, 32-bit data, one clock, sync reset
//
// Our own choice: register access over Wishbone.
module leadoff_and_channel_config
  import leadoff_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // lead-off controls
  output logic [7:0] thresh_pos_sel_o,
  output logic [7:0] thresh_neg_sel_o,
  output logic [3:0] current_sel_o,
  output logic detect_ac_select_o,
  // channel one controls
  output logic chan_one_powerdown_o,
  output logic [6:0] gain_sel_o,
  output logic [9:0] source_sel_o,
  output logic source_reserved_o
);
  // carrier of the stored bytes
  cfg_regs_if regs_if ();
  // bus state and answer next values
  bus_state_t state;
  bus_state_t next_state;
  logic [31:0] next_dat;
  logic next_ack;
  logic next_err;
  // request qualifiers
  logic req;
  logic hit_lead_off_control;
  logic hit_ch1;
  logic hit_any;
  logic wr_lead_off_control;
  logic wr_ch1;
  logic [7:0] rd_byte;
  // stored bytes and their next values
  logic [7:0] lead_off_control;
  logic [7:0] channel_one_settings;
  logic [7:0] next_lead_off_control;
  logic [7:0] next_channel_one_settings;
  // single-bit fields taken straight from the stored bytes
  logic detect_ac_bit;
  logic powerdown_bit;
  // decoder results
  logic [7:0] dec_pos;
  logic [7:0] dec_neg;
  logic [3:0] dec_cur;
  logic [9:0] dec_src;
  logic [6:0] dec_gain;
  logic dec_rsv;
  // control next values
  logic [7:0] next_thresh_pos_sel;
  logic [7:0] next_thresh_neg_sel;
  logic [3:0] next_current_sel;
  logic next_detect_ac_select;
  logic next_chan_one_powerdown;
  logic [6:0] next_gain_sel;
  logic [9:0] next_source_sel;
  logic next_source_reserved;

  // address decode; word address index is byte address over four
  assign req = wb_cyc_i && wb_stb_i && (state == bus_idle);
  assign hit_lead_off_control = (wb_adr_i == {22'h00_0000, lead_off_control_idx, 2'b00});
  assign hit_ch1 = (wb_adr_i == {22'h00_0000, channel_one_settings_idx, 2'b00});
  assign hit_any = hit_lead_off_control || hit_ch1;

  // write strobes; only the low byte lane holds a register
  assign wr_lead_off_control = req && wb_we_i && wb_sel_i[0] && hit_lead_off_control;
  assign wr_ch1 = req && wb_we_i && wb_sel_i[0] && hit_ch1;

  // read byte by address; unmapped reads return zero
  // both bytes sit in the low lane of the 32-bit word
  always_comb begin
    rd_byte = 8'h00;
    if (hit_lead_off_control) begin
      rd_byte = lead_off_control;
    end else if (hit_ch1) begin
      rd_byte = channel_one_settings;
    end
  end

  // bus handshake next values
  // the ack cycle never retakes a request, so each answer is one pulse
  always_comb begin
    next_state = state;
    next_ack = 1'b0;
    next_err = 1'b0;
    next_dat = 32'h0000_0000;
    unique case (state)
      bus_idle: begin
        if (req) begin
          next_state = bus_ack;
          next_ack = hit_any;
          next_err = !hit_any; // unmapped address
          next_dat = {24'h00_0000, rd_byte};
        end
      end
      bus_ack: begin
        next_state = bus_idle; // master drops its request here
      end
    endcase
  end

  // bus flops; answers clear on the next edge
  // read data drops with ack so no stale byte lingers on the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= bus_idle;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      state <= next_state;
      wb_ack_o <= next_ack;
      wb_err_o <= next_err;
      wb_dat_o <= next_dat;
    end
  end

  // register next values
  // fixed bits are stored as written; the host keeps them right
  always_comb begin
    next_lead_off_control = lead_off_control;
    next_channel_one_settings = channel_one_settings;
    if (wr_lead_off_control) begin
      next_lead_off_control = wb_dat_i[7:0];
    end
    if (wr_ch1) begin
      next_channel_one_settings = wb_dat_i[7:0];
    end
  end

  // register flops, defaults after reset
  // a write lands on the edge that takes the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lead_off_control <= lead_off_control_rst;
      channel_one_settings <= channel_one_settings_rst;
    end else begin
      lead_off_control <= next_lead_off_control;
      channel_one_settings <= next_channel_one_settings;
    end
  end

  // single-bit fields
  assign detect_ac_bit = lead_off_control[detect_ac_pos];
  assign powerdown_bit = channel_one_settings[powerdown_pos];

  // stored bytes toward the decoder
  assign regs_if.lead_off_control = lead_off_control;
  assign regs_if.channel_one_settings = channel_one_settings;

  // field decode into one-hot selects
  cfg_decode u_decode (
    .regs(regs_if.decode),
    .thresh_pos_sel_o(dec_pos),
    .thresh_neg_sel_o(dec_neg),
    .current_sel_o(dec_cur),
    .source_sel_o(dec_src),
    .gain_sel_o(dec_gain),
    .source_reserved_o(dec_rsv)
  );

  // control next values from the decoder and the single-bit fields
  // registering them keeps every control output free of decode glitches
  always_comb begin
    next_thresh_pos_sel = dec_pos;
    next_thresh_neg_sel = dec_neg;
    next_current_sel = dec_cur;
    next_detect_ac_select = detect_ac_bit;
    next_chan_one_powerdown = powerdown_bit;
    next_gain_sel = dec_gain;
    next_source_sel = dec_src;
    next_source_reserved = dec_rsv;
  end

  // registered control outputs, one cycle behind the stored bytes
  // reset shows code zero of every field, matching the stored defaults
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thresh_pos_sel_o <= thresh_sel_rst;
      thresh_neg_sel_o <= thresh_sel_rst;
      current_sel_o <= current_sel_rst;
      detect_ac_select_o <= 1'b0;
      chan_one_powerdown_o <= 1'b0;
      gain_sel_o <= gain_sel_rst;
      source_sel_o <= source_sel_rst;
      source_reserved_o <= 1'b0;
    end else begin
      thresh_pos_sel_o <= next_thresh_pos_sel;
      thresh_neg_sel_o <= next_thresh_neg_sel;
      current_sel_o <= next_current_sel;
      detect_ac_select_o <= next_detect_ac_select;
      chan_one_powerdown_o <= next_chan_one_powerdown;
      gain_sel_o <= next_gain_sel;
      source_sel_o <= next_source_sel;
      source_reserved_o <= next_source_reserved;
    end
  end
endmodule

// File: testbench/leadoff_checker.sv
// bus and decode checks for the lead-off and channel one bank
// assumes the master keeps sel[0] high
module leadoff_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // decoded controls
  input wire logic [7:0] thresh_pos_sel_o,
  input wire logic [7:0] thresh_neg_sel_o,
  input wire logic [6:0] gain_sel_o,
  input wire logic [9:0] source_sel_o,
  input wire logic source_reserved_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] lo_a = 32'h0000_000c;
  localparam logic [31:0] ch_a = 32'h0000_0010;
  logic take;
  // request taken while the slave is idle
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr_lo; take && wb_we_i && wb_adr_i == lo_a; endsequence
  sequence s_wr_ch; take && wb_we_i && wb_adr_i == ch_a; endsequence
  property p_map; take && (wb_adr_i == lo_a || wb_adr_i == ch_a) |=> wb_ack_o && !wb_err_o;
  endproperty
  a_map: assert property (p_map) else $error("mapped access not acked");
  property p_unmap; take && wb_adr_i != lo_a && wb_adr_i != ch_a |=> wb_err_o && !wb_ack_o;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  property p_thr; s_wr_lo |=> ##1 thresh_pos_sel_o == (8'h01 << $past(wb_dat_i[7:5], 2));
  endproperty
  a_thr: assert property (p_thr) else $error("threshold decode wrong");
  property p_pair; thresh_neg_sel_o == thresh_pos_sel_o && $onehot(thresh_pos_sel_o); endproperty
  a_pair: assert property (p_pair) else $error("threshold sides differ");
  property p_gain; s_wr_ch |=> ##1 gain_sel_o == (7'h01 << $past(wb_dat_i[6:4], 2)); endproperty
  a_gain: assert property (p_gain) else $error("gain decode wrong");
  property p_src; s_wr_ch |=> ##1 source_sel_o == (10'h001 << $past(wb_dat_i[3:0], 2))
    && source_reserved_o == ($past(wb_dat_i[3:0], 2) >= 4'ha); endproperty
  a_src: assert property (p_src) else $error("source decode wrong");
  property p_rst; $fell(rst_i) |-> gain_sel_o == 7'h01 && source_sel_o == 10'h001; endproperty
  a_rst: assert property (p_rst) else $error("decode not at defaults");
endmodule

// File: testbench/testbench.sv
// self-checking bench for the lead-off and channel one bank
// assumes byte addresses 0x0c and 0x10 and a one-cycle bus answer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic wb_ack_o, wb_err_o, detect_ac_select_o, chan_one_powerdown_o, source_reserved_o;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
  logic [7:0] thresh_pos_sel_o, thresh_neg_sel_o, lo = 8'h10, ch = 8'h00, b;
  logic [3:0] wb_sel_i = 4'h1, current_sel_o;
  logic [6:0] gain_sel_o;
  logic [9:0] source_sel_o;
  logic [72:0] q[$], note, got;
  int n_fail = 0, tests_run = 0;
  leadoff_and_channel_config i_leadoff_and_channel_config (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .thresh_pos_sel_o(thresh_pos_sel_o), .thresh_neg_sel_o(thresh_neg_sel_o),
    .current_sel_o(current_sel_o), .detect_ac_select_o(detect_ac_select_o),
    .chan_one_powerdown_o(chan_one_powerdown_o), .gain_sel_o(gain_sel_o),
    .source_sel_o(source_sel_o), .source_reserved_o(source_reserved_o)
  );
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  // one bus cycle; a read notes its expected answer
  task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    if (!w) q.push_back({a != 32'h0000_000c && a != 32'h0000_0010,
      24'h00_0000, a == 32'h0000_000c ? lo : a == 32'h0000_0010 ? ch : 8'h00, ch[7], lo[0],
      4'h1 << lo[3:2], 8'h01 << lo[7:5], 8'h01 << lo[7:5], 7'h01 << ch[6:4],
      10'h001 << ch[3:0], ch[3:0] >= 4'ha});
    do begin
      @(posedge clk_i);
      n++;
    end while (!(wb_ack_o || wb_err_o) && n < 50);
    if (n == 50) n_fail++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (w && a == 32'h0000_000c) lo = d;
    if (w && a == 32'h0000_0010) ch = d;
  endtask
  // compare each read answer with the oldest note
  always @(posedge clk_i) begin
    if ((wb_ack_o || wb_err_o) && !wb_we_i) begin
      note = q.pop_front();
      got = {wb_err_o, wb_dat_o, chan_one_powerdown_o, detect_ac_select_o, current_sel_o,
        thresh_pos_sel_o, thresh_neg_sel_o, gain_sel_o, source_sel_o, source_reserved_o};
      tests_run++;
      if (got !== note) begin
        n_fail++;
        $display("wrong value at %0t: got %h expected %h", $time, got, note);
      end
    end
  end
  task end_sim;
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // reset, then the tests in turn
  initial begin
    void'($urandom(32'h8238));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(32'h0000_000c, 1'b0, 8'h00);
    xfer(32'h0000_0010, 1'b0, 8'h00);
    $display("reset defaults done");
    repeat (16) begin
      b = (8'($urandom()) & 8'hed) | 8'h10;
      xfer(32'h0000_000c, 1'b1, b);
      xfer(32'h0000_000c, 1'b0, 8'h00);
    end
    $display("lead-off fields done");
    for (int i = 0; i < 16; i++) begin
      b = {1'b0, 3'(i), 4'(i)};
      if (i == 3) b[6:4] = 3'h1;
      if (i == 15) b = 8'h81;
      xfer(32'h0000_0010, 1'b1, b);
      xfer(32'h0000_0010, 1'b0, 8'h00);
    end
    $display("channel fields done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    lo = 8'h10;
    ch = 8'h00;
    xfer(32'h0000_000c, 1'b0, 8'h00);
    xfer(32'h0000_0010, 1'b0, 8'h00);
    $display("mid-run reset done");
    xfer(32'h0000_0008, 1'b1, 8'hff);
    xfer(32'h0000_0014, 1'b0, 8'h00);
    xfer(32'h0000_000c, 1'b0, 8'h00);
    $display("unmapped access done");
    end_sim;
  end
  // watchdog against a hung bus
  initial begin
    #100000;
    n_fail++;
    end_sim;
  end
endmodule
bind leadoff_and_channel_config leadoff_checker i_leadoff_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .thresh_pos_sel_o(thresh_pos_sel_o), .thresh_neg_sel_o(thresh_neg_sel_o),
  .gain_sel_o(gain_sel_o), .source_sel_o(source_sel_o), .source_reserved_o(source_reserved_o)
);
